/* core/fieldbus_master_state_control.sv */
/*
 * Communication control state machine of a fieldbus master port:
 * power-on self-diagnosis, four-state traffic gating, RUN indicator.
 * Assumes the diagnosis result pins and link events come from other
 * clock domains and are synchronised here.
 */
`timescale 1ns/100ps

// Summary of operation
// R1: Self-diagnose config and port before communicating
// R2: Config check failure sets config error flag
// R3: Port check reports address and controller faults
// R4: Exactly four control states gate all traffic
// R5: Advance Init, PreOp, SafeOp, Op in order
// R6: Errors move state down without software command
// R7: Init blocks all traffic, RUN off
// R8: PreOp mailbox only, RUN flashes, then SafeOp
// R9: SafeOp mailbox and inputs, RUN flashes
// R10: Op allows all traffic, RUN steady on
// R11: RUN indicator always reflects current state
// R12: Program gates data on per-slave status bits
// R13: Two-bit state register, reset forces Init
module fieldbus_master_state_control
    import fbm_pkg::*;
(
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic config_present, // Network configuration stored
    input wire logic config_valid, // Stored configuration checks good
    input wire logic hw_address_ok, // Port hardware address valid
    input wire logic comm_controller_ok, // Port controller responding
    input wire logic setup_done, // Initial network setup finished
    input wire logic slaves_safeop, // Slaves reached safe-operational
    input wire logic link_error, // Communication error seen
    output logic net_config_error_flag, // Config check failed
    output logic hw_address_error_flag, // Address fault found
    output logic comm_controller_error_flag, // Controller fault found
    output logic diag_done, // Self-diagnosis finished
    output logic [1:0] ctrl_state, // 0 Init .. 3 Operational
    output logic mailbox_enable, // Mailbox transfers allowed
    output logic cyclic_in_enable, // Cyclic inputs allowed
    output logic cyclic_out_enable, // Cyclic outputs allowed
    output logic run_led // RUN indicator
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic cfg_pres_s, cfg_ok_s, addr_ok_s, ctl_ok_s;
    logic setup_s, safeop_s, err_s;
    logic [6:0] raw_in, sync_in;

    assign raw_in = {config_present, config_valid, hw_address_ok,
                     comm_controller_ok, setup_done, slaves_safeop,
                     link_error};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            fbm_sync2 u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .async_in(raw_in[gi]),
                .sync_out(sync_in[gi])
            );
        end
    endgenerate

    assign {cfg_pres_s, cfg_ok_s, addr_ok_s, ctl_ok_s,
            setup_s, safeop_s, err_s} = sync_in;

    ////////////////////////////////////////////////////////////////////
    // Power-on self-diagnosis

    diag_state_t diag_q;
    logic [DIAG_CNT_W-1:0] diag_cnt_q;
    logic diag_ok;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_q <= DG_IDLE;
            diag_cnt_q <= '0;
        end else if (clk_en) begin
            case (diag_q)
                DG_IDLE: begin
                    diag_q <= DG_RUN;
                    diag_cnt_q <= '0;
                end
                DG_RUN: begin
                    if (diag_cnt_q == DIAG_CNT_W'(DIAG_CYC - 1)) begin
                        diag_q <= DG_DONE; // R1
                    end else begin
                        diag_cnt_q <= diag_cnt_q + 1'b1;
                    end
                end
                DG_DONE: diag_q <= DG_DONE;
                default: diag_q <= DG_IDLE;
            endcase
        end
    end

    // Results latched once at the end of the diagnosis window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            net_config_error_flag <= 1'b0;
            hw_address_error_flag <= 1'b0;
            comm_controller_error_flag <= 1'b0;
        end else if (clk_en && diag_q == DG_RUN &&
                     diag_cnt_q == DIAG_CNT_W'(DIAG_CYC - 1)) begin
            net_config_error_flag <= cfg_pres_s && !cfg_ok_s; // R2
            hw_address_error_flag <= !addr_ok_s; // R3
            comm_controller_error_flag <= !ctl_ok_s; // R3
        end
    end

    assign diag_done = (diag_q == DG_DONE);
    assign diag_ok = diag_done && !net_config_error_flag &&
                     !hw_address_error_flag && !comm_controller_error_flag;

    ////////////////////////////////////////////////////////////////////
    // Control state machine

    ctrl_state_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (diag_ok && cfg_pres_s && !err_s) begin
                    state_d = ST_PREOP; // R5 R7 R8
                end
            end
            ST_PREOP: begin
                if (err_s || !cfg_pres_s) begin
                    state_d = ST_INIT; // R6
                end else if (setup_s) begin
                    state_d = ST_SAFEOP; // R8
                end
            end
            ST_SAFEOP: begin
                if (err_s || !cfg_pres_s) begin
                    state_d = ST_PREOP; // R6
                end else if (safeop_s) begin
                    state_d = ST_OP; // R9
                end
            end
            ST_OP: begin
                if (err_s || !cfg_pres_s) begin
                    state_d = ST_SAFEOP; // R6
                end
            end
            default: state_d = ST_INIT;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ctrl_state_t'(STATE_RESET); // R13
        end else if (clk_en) begin
            state_q <= state_d; // R4
        end
    end

    assign ctrl_state = state_q; // R13

    ////////////////////////////////////////////////////////////////////
    // Traffic gating, registered

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mailbox_enable <= 1'b0;
            cyclic_in_enable <= 1'b0;
            cyclic_out_enable <= 1'b0;
        end else if (clk_en) begin
            mailbox_enable <= (state_d != ST_INIT); // R7 R8
            cyclic_in_enable <= (state_d == ST_SAFEOP) ||
                                (state_d == ST_OP); // R9
            cyclic_out_enable <= (state_d == ST_OP); // R10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // RUN indicator

    logic [FLASH_CNT_W-1:0] flash_cnt_q;
    logic flash_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else if (clk_en) begin
            if (flash_cnt_q == FLASH_CNT_W'(FLASH_HALF_CYC - 1)) begin
                flash_cnt_q <= '0;
                flash_q <= !flash_q;
            end else begin
                flash_cnt_q <= flash_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_led <= 1'b0;
        end else if (clk_en) begin
            case (state_d)
                ST_INIT: run_led <= 1'b0; // R7 R11
                ST_PREOP, ST_SAFEOP: run_led <= flash_q; // R11
                ST_OP: run_led <= 1'b1; // R10 R11
                default: run_led <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    chk_init_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_INIT |-> !mailbox_enable && !cyclic_in_enable &&
        !cyclic_out_enable && !run_led) // R7
        else $error("traffic or RUN active in init");

    chk_preop_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_PREOP |-> mailbox_enable && !cyclic_in_enable &&
        !cyclic_out_enable) // R8
        else $error("wrong gating in pre-operational");

    chk_safeop_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_SAFEOP |-> mailbox_enable && cyclic_in_enable &&
        !cyclic_out_enable) // R9
        else $error("wrong gating in safe-operational");

    chk_op_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ST_OP |-> mailbox_enable && cyclic_out_enable &&
        cyclic_in_enable && run_led) // R10
        else $error("wrong gating or RUN in operational");

    chk_order_up: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && state_d != state_q && state_d > state_q |->
        state_d == ctrl_state_t'(state_q + 2'h1)) // R5
        else $error("state skipped a step upward");

    chk_no_comm_early: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !diag_done |-> state_q == ST_INIT) // R1
        else $error("left init before self-diagnosis");

    chk_error_drops: assert property (@(posedge core_clk) // R6
        disable iff (!rst_n)
        clk_en && err_s && state_q != ST_INIT |=> $past(state_q) > state_q)
        else $error("error did not lower the state");

    chk_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        net_config_error_flag && diag_done |-> state_q == ST_INIT) // R2
        else $error("left init with config error");

    chk_flags_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
        diag_done && $past(diag_done) |-> $stable(hw_address_error_flag)
        && $stable(comm_controller_error_flag)) // R3
        else $error("port fault flags changed after diagnosis");

endmodule // fieldbus_master_state_control

/* core/fbm_pkg.sv */
/*
 * Constants and types for the fieldbus master control state block.
 * Assumes a single 100 MHz core clock.
 */
package fbm_pkg;

    // Control state encoding: 0 Init .. 3 Operational
    typedef enum logic [1:0] {
        ST_INIT,
        ST_PREOP,
        ST_SAFEOP,
        ST_OP
    } ctrl_state_t;

    localparam logic [1:0] STATE_RESET = 2'h0;

    // Self-diagnosis sequencing
    typedef enum logic [1:0] {
        DG_IDLE,
        DG_RUN,
        DG_DONE
    } diag_state_t;

    // Flash period of the RUN indicator
    localparam int FLASH_HALF_MS = 1;
    localparam int CLK_MHZ = 100;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
    localparam int FLASH_CNT_W = 24;

    // Self-diagnosis settle time before results are taken
    localparam int DIAG_NS = 100;
    localparam int CLK_NS = 10;
    localparam int DIAG_CYC = (DIAG_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIAG_CNT_W = 8;

endpackage

/* core/fbm_sync2.sv */
/*
 * Two-stage synchroniser for one asynchronous level.
 * Assumes the input may change at any time relative to core_clk.
 */
`timescale 1ns/100ps
module fbm_sync2 (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic clk_en, // Clock enable
    input wire logic async_in, // Unsynchronised level
    output logic sync_out // Synchronised level
);
    logic meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // fbm_sync2

/* test/slave_chain_model.sv */
/*
 * Behavioural model of the chain of fieldbus slaves on the far side.
 * Assumes the master's gating outputs are levels in the core_clk domain.
 */
`timescale 1ns/100ps
module slave_chain_model (
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic mailbox_enable, // Master allows mailbox traffic
    input wire logic cyclic_in_enable, // Master allows cyclic inputs
    input wire logic slow, // Slaves take longer to start up
    input wire logic fail, // Bench orders a link error
    output logic setup_done, // Slave setup finished
    output logic slaves_safeop, // Slaves ready for operational
    output logic link_error // Link error seen
);
    logic [7:0] cnt_q;

    ////////////////////////////////////////////////////////////////////
    // Slaves follow the master up one step at a time; they drop back only when it returns to Init
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            setup_done <= 1'b0;
            slaves_safeop <= 1'b0;
        end else if (!mailbox_enable) begin
            cnt_q <= 8'h00;
            setup_done <= 1'b0;
            slaves_safeop <= 1'b0;
        end else if (cnt_q != (slow ? 8'h28 : 8'h03)) begin
            cnt_q <= cnt_q + 8'h01;
        end else if (!setup_done) begin
            cnt_q <= 8'h00;
            setup_done <= 1'b1;
        end else if (cyclic_in_enable) begin
            slaves_safeop <= 1'b1;
        end
    end

    // Slaves only report status; gating data use is the program's job
    assign link_error = fail;

endmodule // slave_chain_model

/* test/fieldbus_master_state_control_tb.sv */
/*
 * Self-checking bench for the fieldbus master control state block.
 * Assumes the slave chain model drives the far-side status levels.
 */
`timescale 1ns/100ps
module fieldbus_master_state_control_tb;
    logic core_clk, rst_n, clk_en, cfg_p, cfg_v, addr_ok, ctl_ok;
    logic setup_done, slaves_safeop, link_error, slow, fail;
    logic cfg_err, addr_err, ctl_err, diag_done, mb, ci, co, run_led;
    logic [1:0] ctrl_state, prev;
    logic [4:0] exp_q[$];
    integer seed = 62786;
    integer miscompares = 0;
    integer checked = 0;
    integer i;

    fieldbus_master_state_control uut (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .config_present(cfg_p), .config_valid(cfg_v),
        .hw_address_ok(addr_ok), .comm_controller_ok(ctl_ok),
        .setup_done(setup_done), .slaves_safeop(slaves_safeop),
        .link_error(link_error), .net_config_error_flag(cfg_err),
        .hw_address_error_flag(addr_err),
        .comm_controller_error_flag(ctl_err), .diag_done(diag_done),
        .ctrl_state(ctrl_state), .mailbox_enable(mb),
        .cyclic_in_enable(ci), .cyclic_out_enable(co), .run_led(run_led));

    slave_chain_model slaves (.core_clk(core_clk), .rst_n(rst_n),
        .mailbox_enable(mb), .cyclic_in_enable(ci), .slow(slow),
        .fail(fail), .setup_done(setup_done),
        .slaves_safeop(slaves_safeop), .link_error(link_error));

    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        clk_en <= ($random(seed) & 3) != 0;
    end

    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input string name, input logic [4:0] e,
                       input logic [4:0] s);
        checked = checked + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %b seen %b", name, e, s);
        end
    endtask

    task automatic timed_out(input string name);
        miscompares = miscompares + 1;
        $display("[ERR] %s expected done seen timeout", name);
        stop_test;
    endtask

    // Expected state with its traffic gates
    function automatic logic [4:0] exp_of(input logic [1:0] s);
        return {s, s != 2'h0, s[1], s == 2'h3};
    endfunction

    task automatic push_walk(input logic up);
        exp_q.push_back(exp_of(up ? 2'h1 : 2'h2));
        exp_q.push_back(exp_of(up ? 2'h2 : 2'h1));
        exp_q.push_back(exp_of(up ? 2'h3 : 2'h0));
    endtask

    ////////////////////////////////////////////////////////////////////
    // Compare every change of control state with the oldest note
    always @(negedge core_clk) begin
        if (!rst_n) begin
            prev = 2'h0;
        end else if (ctrl_state !== prev) begin
            prev = ctrl_state;
            if (exp_q.size() == 0) begin
                miscompares = miscompares + 1;
                $display("[ERR] ctrl_state expected hold seen %b",
                         ctrl_state);
            end else begin
                cmp("state_gates", exp_q.pop_front(),
                    {ctrl_state, mb, ci, co});
            end
            if (ctrl_state[0] === ctrl_state[1]) begin
                cmp("run_led", {4'h0, ctrl_state[0]}, {4'h0, run_led});
            end
        end
    end

    task automatic wait_state(input logic [1:0] s);
        integer n;
        n = 0;
        while ((ctrl_state !== s || exp_q.size() != 0) && n < 3000) begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (n == 3000) timed_out("ctrl_state");
    endtask

    task automatic run_case(input logic [3:0] c);
        integer n;
        rst_n <= 1'b0;
        {cfg_p, cfg_v, addr_ok, ctl_ok} <= c;
        fail <= 1'b0;
        slow <= 1'($random(seed));
        repeat (8) @(posedge core_clk);
        cmp("reset_state", 5'h00, {ctrl_state, mb, ci, co});
        if (c == 4'hf) push_walk(1'b1);
        rst_n <= 1'b1;
        n = 0;
        while (diag_done !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (n == 500) timed_out("diag_done");
        repeat (2) @(posedge core_clk);
        cmp("diag_flags", {2'h0, c[3] & ~c[2], ~c[1], ~c[0]},
            {2'h0, cfg_err, addr_err, ctl_err});
        if (c == 4'hf) begin
            wait_state(2'h3);
        end else begin
            repeat (60) @(posedge core_clk);
            cmp("init_hold", 5'h00, {ctrl_state, mb, ci, co});
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {cfg_p, cfg_v, addr_ok, ctl_ok, slow, fail} = 6'h00;
        run_case(4'hb);
        run_case(4'hd);
        run_case(4'he);
        run_case(4'h7);
        run_case(4'hf);
        for (i = 0; i < 2; i = i + 1) begin
            push_walk(1'b0);
            if (i == 0) fail <= 1'b1;
            else cfg_p <= 1'b0;
            wait_state(2'h0);
            repeat (20) @(posedge core_clk);
            push_walk(1'b1);
            fail <= 1'b0;
            cfg_p <= 1'b1;
            wait_state(2'h3);
        end
        stop_test;
    end

endmodule // fieldbus_master_state_control_tb
